// ### common/acm_pkg.sv
package acm_pkg;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DPORT    = 8'h04;
  localparam logic [7:0] OFS_TCPFLAG  = 8'h08;
  localparam logic [7:0] OFS_V6NHDR   = 8'h0c;
  localparam logic [7:0] OFS_V6ADDR   = 8'h10;
  localparam logic [7:0] OFS_V6MASK   = 8'h14;
  localparam logic [7:0] OFS_ETYPE    = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_MATCHCNT = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_FTYPE_LSB  = 0;
  localparam int CTRL_DMODE_LSB  = 4;
  localparam int CTRL_NHSPEC_BIT = 8;
  localparam int CTRL_SASPEC_BIT = 9;
  localparam int CTRL_ETSPEC_BIT = 10;
  localparam int CTRL_EN_BIT     = 15;
  localparam int DPORT_HI_LSB    = 16;
  localparam int ETYPE_LSB       = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_DPORT   = 32'hffff_0000;
  localparam logic [9:0]  RST_TCPFLAG = 10'h3ff;
  localparam logic [7:0]  RST_V6NHDR  = 8'h00;
  localparam logic [31:0] RST_V6ADDR  = 32'h0000_0000;
  localparam logic [31:0] RST_V6MASK  = 32'h0000_0000;
  localparam logic [15:0] RST_ETYPE   = 16'h0600;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int MAX_ENTRIES = 512;
  localparam int PORT_W      = 16;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    ACM_FT_ANY   = 4'h0,
    ACM_FT_ETYPE = 4'h1,
    ACM_FT_ARP   = 4'h2,
    ACM_FT_IPV4  = 4'h3,
    ACM_FT_IPV6  = 4'h4
  } acm_ftype_e;

  typedef enum logic [1:0] {
    ACM_DP_ANY   = 2'h0,
    ACM_DP_SPEC  = 2'h1,
    ACM_DP_RANGE = 2'h2
  } acm_dmode_e;

  // Three-valued flag setting: 0 clear, 1 set, 2/3 don't care
  localparam logic [1:0] FLAG_CLEAR = 2'h0;
  localparam logic [1:0] FLAG_SET   = 2'h1;

endpackage

// ### common/acm_hdr_if.sv
// Frame header fields handed to the comparator
interface acm_hdr_if;
  logic        is_tcp;
  logic        is_udp;
  logic        is_ipv6;
  logic [15:0] dport;
  logic [4:0]  flags;
  logic [7:0]  next_hdr;
  logic [31:0] src_v6;
  logic [15:0] etype;
  logic        hit;

  modport src (output is_tcp, is_udp, is_ipv6, dport, flags, next_hdr, src_v6, etype, input hit);
  modport cmp (input is_tcp, is_udp, is_ipv6, dport, flags, next_hdr, src_v6, etype, output hit);
endinterface

// ### rtl/acm_compare.sv
// Combinational comparison of one entry against one header
module acm_compare (
  // Header and result
  acm_hdr_if.cmp          hdr,
  // Entry configuration
  input wire logic [31:0] ctrl,
  input wire logic [31:0] dport_cfg,
  input wire logic [9:0]  tcp_cfg,
  input wire logic [7:0]  nh_cfg,
  input wire logic [31:0] addr_cfg,
  input wire logic [31:0] mask_cfg,
  input wire logic [15:0] etype_cfg
);

  // Three-valued flag test
  function automatic logic flag_ok(input logic [1:0] cfg, input logic bit_in);
    flag_ok = (cfg == acm_pkg::FLAG_CLEAR) ? !bit_in :
              (cfg == acm_pkg::FLAG_SET)   ?  bit_in : 1'b1;
  endfunction

  wire logic [3:0]  ftype   = ctrl[acm_pkg::CTRL_FTYPE_LSB +: 4];
  wire logic [1:0]  dmode   = ctrl[acm_pkg::CTRL_DMODE_LSB +: 2];
  wire logic [15:0] lo      = dport_cfg[15:0];
  wire logic [15:0] hi      = dport_cfg[acm_pkg::DPORT_HI_LSB +: 16];
  wire logic        l4      = hdr.is_tcp | hdr.is_udp;

  // Destination port
  wire logic dp_ok = (dmode == acm_pkg::ACM_DP_RANGE) ?
                       (l4 && hdr.dport >= lo && hdr.dport <= hi) :
                     (dmode == acm_pkg::ACM_DP_SPEC) ?
                       (l4 && hdr.dport == lo) : 1'b1;

  // TCP flags, non-TCP frames pass (flags ordered fin,syn,psh,ack,urg)
  wire logic fin_ok = !hdr.is_tcp || flag_ok(tcp_cfg[1:0], hdr.flags[0]);
  wire logic syn_ok = !hdr.is_tcp || flag_ok(tcp_cfg[3:2], hdr.flags[1]);
  wire logic psh_ok = !hdr.is_tcp || flag_ok(tcp_cfg[5:4], hdr.flags[2]);
  wire logic ack_ok = !hdr.is_tcp || flag_ok(tcp_cfg[7:6], hdr.flags[3]);
  wire logic urg_ok = !hdr.is_tcp || flag_ok(tcp_cfg[9:8], hdr.flags[4]);

  // IPv6 fields only for an IPv6 entry
  wire logic is_v6e = (ftype == acm_pkg::ACM_FT_IPV6);
  wire logic nh_ok  = !ctrl[acm_pkg::CTRL_NHSPEC_BIT] ||
                      (hdr.next_hdr == nh_cfg);
  wire logic sa_ok  = !ctrl[acm_pkg::CTRL_SASPEC_BIT] ||
                      (((hdr.src_v6 ^ addr_cfg) & mask_cfg) == 32'h0000_0000);
  wire logic v6_ok  = !is_v6e || (hdr.is_ipv6 && nh_ok && sa_ok);

  // EtherType fields only for an EtherType entry
  wire logic is_ete = (ftype == acm_pkg::ACM_FT_ETYPE);
  wire logic et_ok  = !is_ete || !ctrl[acm_pkg::CTRL_ETSPEC_BIT] ||
                      (hdr.etype == etype_cfg[acm_pkg::ETYPE_LSB +: 16]);

  // All enabled comparisons must pass
  assign hdr.hit = ctrl[acm_pkg::CTRL_EN_BIT] && dp_ok && fin_ok && syn_ok && psh_ok &&
                   ack_ok && urg_ok && v6_ok && et_ok;

endmodule

// ### rtl/acm_matcher.sv
module acm_matcher #(
  parameter int ENTRY_INDEX = 0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parsed header from ingress
  input  wire logic        hdr_valid,
  input  wire logic        hdr_is_tcp,
  input  wire logic        hdr_is_udp,
  input  wire logic        hdr_is_ipv6,
  input  wire logic [15:0] hdr_dport,
  input  wire logic [4:0]  hdr_flags,
  input  wire logic [7:0]  hdr_next_hdr,
  input  wire logic [31:0] hdr_src_v6,
  input  wire logic [15:0] hdr_etype,
  // Match result
  output logic             match_valid,
  output logic             match_hit
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (ENTRY_INDEX < 0 || ENTRY_INDEX >= acm_pkg::MAX_ENTRIES) begin : g_chk
    $error("ENTRY_INDEX out of range");
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [31:0] ctrl;
  logic [31:0] dport_cfg;
  logic [9:0]  tcp_cfg;
  logic [7:0]  nh_cfg;
  logic [31:0] addr_cfg;
  logic [31:0] mask_cfg;
  logic [15:0] etype_cfg;
  logic [31:0] hit_cnt;

  // APB decode
  wire logic setup    = psel && !penable;
  wire logic wr_take  = psel && penable && pwrite && pready;
  wire logic rd_phase = setup && !pwrite;
  wire logic mapped   = (paddr == acm_pkg::OFS_CTRL)    || (paddr == acm_pkg::OFS_DPORT)   ||
                        (paddr == acm_pkg::OFS_TCPFLAG) || (paddr == acm_pkg::OFS_V6NHDR)  ||
                        (paddr == acm_pkg::OFS_V6ADDR)  || (paddr == acm_pkg::OFS_V6MASK)  ||
                        (paddr == acm_pkg::OFS_ETYPE)   || (paddr == acm_pkg::OFS_STATUS)  ||
                        (paddr == acm_pkg::OFS_MATCHCNT);
  wire logic wr_ok    = wr_take && mapped;

  // Read multiplexer
  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr)
      acm_pkg::OFS_CTRL:     rd_mux = ctrl;
      acm_pkg::OFS_DPORT:    rd_mux = dport_cfg;
      acm_pkg::OFS_TCPFLAG:  rd_mux = {22'h0, tcp_cfg};
      acm_pkg::OFS_V6NHDR:   rd_mux = {24'h000000, nh_cfg};
      acm_pkg::OFS_V6ADDR:   rd_mux = addr_cfg;
      acm_pkg::OFS_V6MASK:   rd_mux = mask_cfg;
      acm_pkg::OFS_ETYPE:    rd_mux = {16'h0000, etype_cfg};
      acm_pkg::OFS_STATUS:   rd_mux = {30'h0, match_hit, match_valid};
      acm_pkg::OFS_MATCHCNT: rd_mux = hit_cnt;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // Access phase: no wait state, answer in the cycle after setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (rd_phase) begin
        prdata <= rd_mux;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl      <= acm_pkg::RST_CTRL;
      dport_cfg <= acm_pkg::RST_DPORT;
      tcp_cfg   <= acm_pkg::RST_TCPFLAG;
      nh_cfg    <= acm_pkg::RST_V6NHDR;
      addr_cfg  <= acm_pkg::RST_V6ADDR;
      mask_cfg  <= acm_pkg::RST_V6MASK;
      etype_cfg <= acm_pkg::RST_ETYPE;
    end else if (ce && wr_ok) begin
      unique case (paddr)
        acm_pkg::OFS_CTRL:    ctrl      <= pwdata;
        acm_pkg::OFS_DPORT:   dport_cfg <= pwdata;
        acm_pkg::OFS_TCPFLAG: tcp_cfg   <= pwdata[9:0];
        acm_pkg::OFS_V6NHDR:  nh_cfg    <= pwdata[7:0];
        acm_pkg::OFS_V6ADDR:  addr_cfg  <= pwdata;
        acm_pkg::OFS_V6MASK:  mask_cfg  <= pwdata;
        acm_pkg::OFS_ETYPE:   etype_cfg <= pwdata[15:0];
        default:              ;
      endcase
    end
  end

  // ****************************************************************
  // Comparison
  // ****************************************************************
  acm_hdr_if hif ();
  assign hif.is_tcp   = hdr_is_tcp;
  assign hif.is_udp   = hdr_is_udp;
  assign hif.is_ipv6  = hdr_is_ipv6;
  assign hif.dport    = hdr_dport;
  assign hif.flags    = hdr_flags;
  assign hif.next_hdr = hdr_next_hdr;
  assign hif.src_v6   = hdr_src_v6;
  assign hif.etype    = hdr_etype;

  acm_compare u_cmp (
    .hdr       (hif),
    .ctrl      (ctrl),
    .dport_cfg (dport_cfg),
    .tcp_cfg   (tcp_cfg),
    .nh_cfg    (nh_cfg),
    .addr_cfg  (addr_cfg),
    .mask_cfg  (mask_cfg),
    .etype_cfg (etype_cfg)
  );

  // Registered result, one cycle after the header; hit counter saturates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_valid <= 1'b0;
      match_hit   <= 1'b0;
      hit_cnt     <= 32'h0000_0000;
    end else if (ce) begin
      match_valid <= hdr_valid;
      match_hit   <= hdr_valid && hif.hit;
      if (wr_ok && paddr == acm_pkg::OFS_MATCHCNT) begin
        hit_cnt <= 32'h0000_0000;
      end else if (hdr_valid && hif.hit && hit_cnt != 32'hffff_ffff) begin
        hit_cnt <= hit_cnt + 32'h0000_0001;
      end
    end
  end

endmodule

// ### verification/acm_matcher_sva.sv
module acm_matcher_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hdr_valid,
  input wire logic match_valid,
  input wire logic match_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Requests
  // ****************
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_head; hdr_valid && ce; endsequence
  a_hit_latency: assert property (s_head |=> match_valid) else $error("no result after header");
  a_no_spurious: assert property (ce && !hdr_valid |=> !match_valid) else $error("result without header");
  a_hit_qual: assert property (match_hit |-> match_valid) else $error("hit outside result");
  a_freeze_state: assert property (!ce |=> $stable(match_valid) && $stable(pready)) else $error("state moved");
  a_apb_answer: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready && ce |=> !pready) else $error("ready too long");
  a_err_qual: assert property (pslverr |-> pready) else $error("error without ready");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable)) else $error("stray ready");
endmodule

// ### verification/acm_parser_model.sv
module acm_parser_model (
  // Clock
  input wire logic clk,
  // Header toward the entry
  output logic        hdr_valid,
  output logic        hdr_is_tcp,
  output logic        hdr_is_udp,
  output logic        hdr_is_ipv6,
  output logic [15:0] hdr_dport,
  output logic [4:0]  hdr_flags,
  output logic [7:0]  hdr_next_hdr,
  output logic [31:0] hdr_src_v6,
  output logic [15:0] hdr_etype
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hdr_valid = 1'b0;
  // One header for one cycle, then the fields turn over
  task automatic send(input logic [2:0] k, input logic [15:0] dp, input logic [4:0] fl,
                      input logic [7:0] nh, input logic [31:0] s, input logic [15:0] e);
    @(posedge clk);
    hdr_valid <= 1'b1;
    {hdr_is_ipv6, hdr_is_udp, hdr_is_tcp, hdr_dport, hdr_flags, hdr_next_hdr, hdr_src_v6, hdr_etype} <=
      {k, dp, fl, nh, s, e};
    @(posedge clk);
    hdr_valid <= 1'b0;
    {hdr_is_ipv6, hdr_is_udp, hdr_is_tcp, hdr_dport, hdr_flags, hdr_next_hdr, hdr_src_v6, hdr_etype} <=
      ~{k, dp, fl, nh, s, e};
  endtask
endmodule

// ### verification/acm_matcher_test.sv
module acm_matcher_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, hv, ti, ui, vi, mv, mh;
  logic [7:0]  paddr, nhd;
  logic [31:0] pwdata, prdata, sa, ctrl, dpc, ad, mk, r, hsa;
  logic [15:0] dpt, lo, hi, ev, et, hdp, het;
  logic [9:0]  tf;
  logic [4:0]  fl, hfl;
  logic [7:0]  nh, hnh;
  logic [3:0]  ft;
  logic [2:0]  kk;
  logic        ex;
  int n_errors = 0, compares = 0, hits;
  acm_parser_model u_parser (.clk(clk), .hdr_valid(hv), .hdr_is_tcp(ti), .hdr_is_udp(ui), .hdr_is_ipv6(vi),
    .hdr_dport(hdp), .hdr_flags(hfl), .hdr_next_hdr(hnh), .hdr_src_v6(hsa), .hdr_etype(het));
  acm_matcher #(.ENTRY_INDEX(511)) i_acm_matcher (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hdr_valid(hv), .hdr_is_tcp(ti), .hdr_is_udp(ui), .hdr_is_ipv6(vi), .hdr_dport(hdp),
    .hdr_flags(hfl), .hdr_next_hdr(hnh), .hdr_src_v6(hsa),
    .hdr_etype(het), .match_valid(mv), .match_hit(mh));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare tasks
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    chk_word({31'h0, e}, {31'h0, g});
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
    chk_bit(1'b0, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk_bit(xe, e);
    chk_word(x, r);
  endtask
  // Expected outcome of one header against the stored entry
  function automatic logic exp_hit(logic t, logic u, logic v, logic [15:0] p, logic [4:0] f, logic [7:0] n,
                                   logic [31:0] s, logic [15:0] e);
    logic ok;
    ok = ctrl[15];
    if (ctrl[5:4] == 2'h1) ok &= (t | u) && p == dpc[15:0];
    if (ctrl[5:4] == 2'h2) ok &= (t | u) && p >= dpc[15:0] && p <= dpc[31:16];
    for (int i = 0; i < 5; i++) if (t && !tf[2*i+1] && tf[2*i] != f[i]) ok = 1'b0;
    if (ctrl[3:0] == 4'h4) begin
      ok &= v;
      if (ctrl[8]) ok &= n == nh;
      if (ctrl[9]) ok &= ((s ^ ad) & mk) == 32'h0;
    end
    if (ctrl[3:0] == 4'h1 && ctrl[10]) ok &= e == ev;
    return ok;
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300us;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst, ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b1, 43'h0};
    void'($urandom(32'h94a578a0));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(acm_pkg::OFS_CTRL, 32'h0, 1'b0);
    rd(acm_pkg::OFS_DPORT, 32'hffff_0000, 1'b0);
    rd(acm_pkg::OFS_TCPFLAG, 32'h3ff, 1'b0);
    rd(acm_pkg::OFS_ETYPE, 32'h0000_0600, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    $display("test reset done");
    for (int c = 0; c < 60; c++) begin
      ft = ($urandom % 3 == 0) ? 4'h1 : (($urandom % 2) ? 4'h4 : 4'h0);
      ctrl = {16'h0, 1'($urandom % 8 != 0), 4'h0, 3'($urandom), 2'h0, 2'($urandom % 3), ft};
      lo = (c == 0) ? 16'h0 : 16'($urandom % 65000);
      hi = (c == 0) ? 16'hffff : lo + 16'($urandom % 500);
      {dpc, tf, nh, ad, mk, ev} = {hi, lo, 10'($urandom), 8'($urandom), $urandom, $urandom, 16'($urandom)};
      wr(acm_pkg::OFS_ETYPE, {16'h0, ev});
      wr(acm_pkg::OFS_MATCHCNT, 32'h0);
      wr(acm_pkg::OFS_DPORT, dpc);
      wr(acm_pkg::OFS_TCPFLAG, {22'h0, tf});
      wr(acm_pkg::OFS_V6NHDR, {24'h0, nh});
      wr(acm_pkg::OFS_V6ADDR, ad);
      wr(acm_pkg::OFS_V6MASK, mk);
      wr(acm_pkg::OFS_CTRL, ctrl);
      rd(acm_pkg::OFS_CTRL, ctrl, 1'b0);
      hits = 0;
      repeat (8) begin
        case ($urandom % 5)
          0: dpt = lo;
          1: dpt = hi;
          2: dpt = lo - 16'h1;
          3: dpt = hi + 16'h1;
          default: dpt = 16'($urandom);
        endcase
        fl = 5'($urandom);
        nhd = ($urandom % 2) ? nh : 8'($urandom);
        sa = ($urandom % 2) ? ad ^ ($urandom & ~mk) : $urandom;
        et = ($urandom % 2) ? ev : 16'($urandom);
        kk = {1'($urandom % 4 != 0), 2'h1 << ($urandom % 3)};
        u_parser.send(kk, dpt, fl, nhd, sa, et);
        #1;
        chk_bit(1'b1, mv);
        ex = exp_hit(kk[0], kk[1], kk[2], dpt, fl, nhd, sa, et);
        chk_bit(ex, mh);
        if (ex) hits++;
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
      end
      rd(acm_pkg::OFS_MATCHCNT, 32'(hits), 1'b0);
    end
    $display("test random entries done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(acm_pkg::OFS_CTRL, 32'h0, 1'b0);
    rd(acm_pkg::OFS_MATCHCNT, 32'h0, 1'b0);
    $display("test mid reset done");
    end_sim();
  end
endmodule
bind acm_matcher acm_matcher_sva i_sva (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .match_valid(match_valid), .match_hit(match_hit));
